// *** count_tick_select.sv ***
// Count clock selection and rising edge detection for one timer.
// Assumes the sources are square levels made by logic on the same clock.

`timescale 1ns/1ns
`default_nettype none

module count_tick_select
	import pwm_timer_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Source levels and choice
	input wire logic [SRC_W-1:0] sources_i,
	input wire logic [1:0] select_i,
	// One-cycle tick
	output logic tick_o
);

	// ==========================================================
	// Edge detection
	logic last;
	wire logic chosen = sources_i[select_i];

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			last <= 1'b0;
		end else begin
			last <= chosen;
		end
	end

	assign tick_o = chosen & !last;

endmodule

`default_nettype wire

// *** eight_bit_pwm_interval_timer.sv ***
// Two eight-bit PWM and interval timers behind an AHB-Lite register slave.
// Assumes count clock sources and stop mode come from logic on CLOCK_I.

`timescale 1ns/1ns
`default_nettype none

// Behaviour
// - Interval mode counts up from zero.
// - After match: toggle, clear, flag, restart.
// - Flag set on match in interval mode only, regardless of enable.
// - Request while flag and enable both set.
// - PWM mode never requests an interrupt.
// - Writing 0 clears flag, 1 ignored.
// - Match with run cleared sets no flag.
// - Enabling with flag set requests at once.
// - Compare zero toggles every count period.
// - Interval mode stopped drives pin low.
// - PWM high until match, low until wrap.
// - PWM stopped holds the pin level.
// - Stop mode freezes counter, resumes after.
// - Stop mode floats or holds the pin; with a pull-up fitted the float request drives it high.
// - Start not aligned; first match early.
// - Two instances, each own interrupt line.
// - Priority fields in the level register.
// - Run clear stops and zeroes counter.
// - New compare applies after match or wrap, at once while run is clear.
// - Output enable selects timer or port.
module eight_bit_pwm_interval_timer
	import pwm_timer_pkg::*;
#(
	parameter logic [NUM_TIMERS-1:0] PULL_UP_FITTED = 2'h0
) (
	// Clock and reset
	input wire logic CLOCK_I,
	input wire logic RST_N_I,
	// AHB-Lite slave
	input wire logic HSEL_I,
	input wire logic [ADDR_W-1:0] HADDR_I,
	input wire logic [1:0] HTRANS_I,
	input wire logic HWRITE_I,
	input wire logic [2:0] HSIZE_I,
	input wire logic [31:0] HWDATA_I,
	input wire logic HREADY_I,
	output logic [31:0] HRDATA_O,
	output logic HREADYOUT_O,
	output logic HRESP_O,
	// Count clock source levels
	input wire logic [SRC_W-1:0] COUNT_SRC_ONE_I,
	input wire logic [SRC_W-1:0] COUNT_SRC_TWO_I,
	// Standby state
	input wire logic STOP_MODE_I,
	// Interrupt lines and levels
	output logic FIRST_TIMER_IRQ_LINE_O,
	output logic SECOND_TIMER_IRQ_LINE_O,
	output logic [1:0] FIRST_IRQ_LEVEL_O,
	output logic [1:0] SECOND_IRQ_LEVEL_O,
	// First shared pin
	input wire logic TIMER_ONE_OUTPUT_PIN_I,
	output logic TIMER_ONE_OUTPUT_PIN_O,
	output logic TIMER_ONE_OUTPUT_PIN_OE_N_O,
	// Second shared pin
	input wire logic TIMER_TWO_OUTPUT_PIN_I,
	output logic TIMER_TWO_OUTPUT_PIN_O,
	output logic TIMER_TWO_OUTPUT_PIN_OE_N_O
);

	// ==========================================================
	// Helpers

	// Tells whether the data phase writes the given register.
	function automatic logic hits(bus_phase_t p, logic [IDX_W-1:0] idx);
		return p.valid & p.write & (p.index == idx);
	endfunction

	// Passes a register byte only when its index is addressed.
	function automatic logic [7:0] pick(logic [IDX_W-1:0] at, logic [IDX_W-1:0] idx,
		logic [7:0] v);
		return (at == idx) ? v : 8'h00;
	endfunction

	// Merges the per-timer read contributions.
	function automatic logic [7:0] merge(logic [NUM_TIMERS-1:0][7:0] v);
		logic [7:0] acc;
		acc = 8'h00;
		for (int k = 0; k < NUM_TIMERS; k++) begin
			acc = acc | v[k];
		end
		return acc;
	endfunction

	// ==========================================================
	// Bus address phase

	bus_phase_t data_phase;
	bus_phase_t next_phase;
	wire logic trans_active = (HTRANS_I == HTRANS_NONSEQ) | (HTRANS_I == HTRANS_SEQ);
	wire logic addr_take = HSEL_I & HREADY_I & trans_active;
	wire logic [IDX_W-1:0] addr_index = HADDR_I[ADDR_W-1:2];
	wire logic read_take = addr_take & !HWRITE_I;
	wire logic [7:0] write_byte = HWDATA_I[7:0];
	wire timer_control_t written = write_byte;

	assign next_phase = {addr_take, HWRITE_I, addr_index};

	always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			data_phase <= '0;
		end else begin
			data_phase <= next_phase;
		end
	end

	// Zero wait states and an OKAY answer for every transfer.
	always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			HREADYOUT_O <= 1'b1;
			HRESP_O <= HRESP_OKAY;
		end else begin
			HREADYOUT_O <= 1'b1;
			HRESP_O <= HRESP_OKAY;
		end
	end

	// ==========================================================
	// Shared registers

	logic [7:0] level_reg;
	logic [7:0] port_reg;
	logic [7:0] standby_reg;
	wire logic wr_level = hits(data_phase, IDX_LEVEL);
	wire logic wr_port = hits(data_phase, IDX_PORT);
	wire logic wr_standby = hits(data_phase, IDX_STANDBY);
	wire logic [7:0] next_level = wr_level ? write_byte : level_reg;
	wire logic [7:0] next_port = wr_port ? (write_byte & PORT_WRITE_MASK) : port_reg;
	wire logic [7:0] next_standby = wr_standby ? write_byte : standby_reg;
	wire logic stop = STOP_MODE_I;
	wire logic float_req = stop & standby_reg[STANDBY_FLOAT_BIT];

	always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			level_reg <= LEVEL_RESET;
			port_reg <= PORT_RESET;
			standby_reg <= STANDBY_RESET;
		end else begin
			level_reg <= next_level;
			port_reg <= next_port;
			standby_reg <= next_standby;
		end
	end

	// ==========================================================
	// Timer instances

	logic [NUM_TIMERS-1:0][SRC_W-1:0] count_src;
	logic [NUM_TIMERS-1:0][7:0] rd_timer;
	logic [NUM_TIMERS-1:0][1:0] irq_level;
	logic [NUM_TIMERS-1:0] irq_line;
	logic [NUM_TIMERS-1:0] pins_in;
	logic [NUM_TIMERS-1:0] pin_out;
	logic [NUM_TIMERS-1:0] pin_oe_n;
	logic [NUM_TIMERS-1:0] pin_level;

	assign count_src = {COUNT_SRC_TWO_I, COUNT_SRC_ONE_I};
	assign pins_in = {TIMER_TWO_OUTPUT_PIN_I, TIMER_ONE_OUTPUT_PIN_I};

	for (genvar i = 0; i < NUM_TIMERS; i++) begin : g_timer
		timer_control_t ctrl;
		timer_control_t next_ctrl;
		pin_request_t pin_req;
		logic [CNT_W-1:0] count;
		logic [CNT_W-1:0] cmp_pending;
		logic [CNT_W-1:0] cmp_active;
		logic wave;
		logic irq;
		logic tick;

		// ==========================================================
		// Register decode
		wire logic wr_ctrl = hits(data_phase, IDX_CTRL[i]);
		wire logic wr_cmp = hits(data_phase, IDX_CMP[i]);
		wire logic run_next = wr_ctrl ? written.run_bit : ctrl.run_bit;
		wire logic pwm = ctrl.pwm_mode;

		// ==========================================================
		// Count clock
		count_tick_select u_tick (
			.clk_i(CLOCK_I),
			.rst_n_i(RST_N_I),
			.sources_i(count_src[i]),
			.select_i(ctrl.clock_select),
			.tick_o(tick)
		);

		// ==========================================================
		// Counter
		// unaligned start
		wire logic advance = tick & ctrl.run_bit & run_next & !stop;
		wire logic match = count == cmp_active;
		wire logic [CNT_W-1:0] count_plus = CNT_W'(count + 8'h01);
		wire logic at_top = count == COUNT_TOP;

		// ==========================================================
		// Match flag
		// flag on match
		wire logic set_flag = advance & match & !pwm;
		wire logic clear_flag = wr_ctrl & !written.match_flag;
		wire logic next_flag = set_flag | (ctrl.match_flag & !clear_flag);

		wire logic [CNT_W-1:0] interval_count = match ? COUNT_ZERO : count_plus;
		wire logic [CNT_W-1:0] running_count = pwm ? count_plus : interval_count;
		wire logic [CNT_W-1:0] held_count = advance ? running_count : count;
		wire logic [CNT_W-1:0] next_count = run_next ? held_count : COUNT_ZERO;

		// ==========================================================
		// Compare value
		// deferred compare
		wire logic [CNT_W-1:0] next_pending = wr_cmp ? write_byte : cmp_pending;
		wire logic wrap = advance & (pwm ? at_top : match);
		wire logic [CNT_W-1:0] loaded = wrap ? cmp_pending : cmp_active;
		wire logic [CNT_W-1:0] next_active = ctrl.run_bit ? loaded : next_pending;

		// ==========================================================
		// Waveform
		// toggle on match
		wire logic interval_wave = run_next & (wave ^ set_flag);
		wire logic pwm_level = next_count < next_active;
		wire logic pwm_wave = (run_next & !stop) ? pwm_level : wave;
		wire logic next_wave = pwm ? pwm_wave : interval_wave;

		always_comb begin
			next_ctrl = wr_ctrl ? written : ctrl;
			next_ctrl.unused = 1'b0;
			next_ctrl.match_flag = next_flag;
		end

		wire logic next_irq = next_flag & next_ctrl.match_irq_enable & !next_ctrl.pwm_mode;

		always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
			if (!RST_N_I) begin
				ctrl <= CTRL_RESET;
				count <= COUNT_ZERO;
				irq <= 1'b0;
			end else begin
				ctrl <= next_ctrl;
				count <= next_count;
				irq <= next_irq;
			end
		end

		always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
			if (!RST_N_I) begin
				cmp_pending <= CMP_RESET;
				cmp_active <= CMP_RESET;
				wave <= 1'b0;
			end else begin
				cmp_pending <= next_pending;
				cmp_active <= next_active;
				wave <= next_wave;
			end
		end

		// ==========================================================
		// Pin and readback
		// timer or port
		assign pin_req = {
			ctrl.output_enable,
			wave,
			port_reg[PORT_DATA_LSB + i],
			port_reg[PORT_DIR_LSB + i]
		};

		shared_pin_driver #(
			.PULL_UP(PULL_UP_FITTED[i])
		) u_pin (
			.clk_i(CLOCK_I),
			.rst_n_i(RST_N_I),
			.request_i(pin_req),
			.stop_i(stop),
			.float_i(float_req),
			.pin_i(pins_in[i]),
			.pin_o(pin_out[i]),
			.pin_oe_n_o(pin_oe_n[i]),
			.level_o(pin_level[i])
		);

		wire logic [7:0] ctrl_read = 8'(ctrl) & CTRL_READ_MASK;
		wire logic [7:0] count_read = pick(addr_index, IDX_COUNT[i], count);
		assign rd_timer[i] = pick(addr_index, IDX_CTRL[i], ctrl_read) | count_read;
		assign irq_line[i] = irq;
		assign irq_level[i] = level_reg[LEVEL_LSB[i] +: 2];
	end

	// ==========================================================
	// Read path

	wire logic [7:0] port_read = port_reg | (8'(pin_level) << PORT_IN_LSB);
	wire logic [7:0] level_read = pick(addr_index, IDX_LEVEL, level_reg);
	wire logic [7:0] port_sel = pick(addr_index, IDX_PORT, port_read);
	wire logic [7:0] standby_sel = pick(addr_index, IDX_STANDBY, standby_reg);
	wire logic [7:0] read_byte = merge(rd_timer) | level_read | port_sel | standby_sel;

	always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			HRDATA_O <= 32'h00000000;
		end else if (read_take) begin
			HRDATA_O <= {24'h000000, read_byte};
		end
	end

	// ==========================================================
	// Outputs

	assign FIRST_TIMER_IRQ_LINE_O = irq_line[0];
	assign SECOND_TIMER_IRQ_LINE_O = irq_line[1];
	assign FIRST_IRQ_LEVEL_O = irq_level[0];
	assign SECOND_IRQ_LEVEL_O = irq_level[1];
	assign TIMER_ONE_OUTPUT_PIN_O = pin_out[0];
	assign TIMER_ONE_OUTPUT_PIN_OE_N_O = pin_oe_n[0];
	assign TIMER_TWO_OUTPUT_PIN_O = pin_out[1];
	assign TIMER_TWO_OUTPUT_PIN_OE_N_O = pin_oe_n[1];

endmodule

`default_nettype wire

// *** eight_bit_pwm_interval_timer_props.sv ***
// Checker of the timer top ports, shadowing software writes.
// Assumes one bus master and zero wait states; watches timer one's pin.
`timescale 1ns/1ns
`default_nettype none
module timer_props
	import pwm_timer_pkg::*;
#(
	parameter logic [NUM_TIMERS-1:0] PULL_UP_FITTED = 2'h0
) (
	// Clock and reset
	input wire logic CLOCK_I,
	input wire logic RST_N_I,
	// Bus
	input wire logic HSEL_I,
	input wire logic [ADDR_W-1:0] HADDR_I,
	input wire logic [1:0] HTRANS_I,
	input wire logic HWRITE_I,
	input wire logic [31:0] HWDATA_I,
	input wire logic HREADY_I,
	// Timer side
	input wire logic STOP_MODE_I,
	input wire logic FIRST_TIMER_IRQ_LINE_O,
	input wire logic SECOND_TIMER_IRQ_LINE_O,
	input wire logic [1:0] FIRST_IRQ_LEVEL_O,
	input wire logic [1:0] SECOND_IRQ_LEVEL_O,
	input wire logic TIMER_ONE_OUTPUT_PIN_O,
	input wire logic TIMER_ONE_OUTPUT_PIN_OE_N_O
);
	// ====
	// Shadow of software writes.
	logic wr_q;
	logic [IDX_W-1:0] idx_q;
	timer_control_t ctl1;
	timer_control_t ctl2;
	logic [7:0] lvl;
	logic [7:0] prt;
	logic [7:0] stb;
	wire logic take = HSEL_I && HREADY_I && HTRANS_I[1] && HWRITE_I;
	wire logic [7:0] wd = HWDATA_I[7:0];
	always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			wr_q <= 1'b0;
			idx_q <= '0;
		end else begin
			wr_q <= take;
			idx_q <= HADDR_I[ADDR_W-1:2];
		end
	end
	always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			ctl1 <= CTRL_RESET;
			ctl2 <= CTRL_RESET;
			lvl <= LEVEL_RESET;
			prt <= PORT_RESET;
			stb <= STANDBY_RESET;
		end else if (wr_q) begin
			if (idx_q == IDX_CTRL[0]) ctl1 <= wd;
			if (idx_q == IDX_CTRL[1]) ctl2 <= wd;
			if (idx_q == IDX_LEVEL) lvl <= wd;
			if (idx_q == IDX_PORT) prt <= wd;
			if (idx_q == IDX_STANDBY) stb <= wd;
		end
	end
	// ====
	// Properties.
	default clocking cb @(posedge CLOCK_I); endclocking
	default disable iff (!RST_N_I);
	sequence s_idle(logic md);
		(ctl1.output_enable && !ctl1.run_bit && ctl1.pwm_mode == md && !STOP_MODE_I)[*3];
	endsequence
	a_irq_one_enable:
	assert property (FIRST_TIMER_IRQ_LINE_O |-> ctl1.match_irq_enable)
		else $error("first request while disabled");
	a_irq_two_enable:
	assert property (SECOND_TIMER_IRQ_LINE_O |-> ctl2.match_irq_enable)
		else $error("second request while disabled");
	a_pwm_no_irq:
	assert property (ctl1.pwm_mode [*2] |-> !FIRST_TIMER_IRQ_LINE_O)
		else $error("request in pulse mode");
	a_stop_pin_low:
	assert property (s_idle(1'b0) |-> !TIMER_ONE_OUTPUT_PIN_O)
		else $error("stopped interval pin not low");
	a_pwm_pin_hold:
	assert property (s_idle(1'b1) |-> $stable(TIMER_ONE_OUTPUT_PIN_O))
		else $error("stopped pulse pin moved");
	a_stop_float:
	assert property ((STOP_MODE_I && stb[STANDBY_FLOAT_BIT] && !PULL_UP_FITTED[0])[*3]
		|-> TIMER_ONE_OUTPUT_PIN_OE_N_O)
		else $error("pin driven in stop");
	a_level_map:
	assert property (FIRST_IRQ_LEVEL_O == lvl[3:2] && SECOND_IRQ_LEVEL_O == lvl[5:4])
		else $error("level fields wrong");
	a_port_select:
	assert property ((!ctl1.output_enable && prt[PORT_DIR_LSB] && !STOP_MODE_I)[*3]
		|-> !TIMER_ONE_OUTPUT_PIN_OE_N_O && TIMER_ONE_OUTPUT_PIN_O == prt[PORT_DATA_LSB])
		else $error("port level not on pin");
endmodule
bind eight_bit_pwm_interval_timer timer_props #(.PULL_UP_FITTED(PULL_UP_FITTED)) i_props (.*);
`default_nettype wire

// *** pin_load.sv ***
// External load on one timer output pin.
// Assumes an active-low enable and no pull-up fitted.
`timescale 1ns/1ns
`default_nettype none
module pin_load (
	// Clock
	input wire logic clk_i,
	// Drive from the block
	input wire logic drive_i,
	input wire logic oe_n_i,
	// Resolved level
	output logic level_o
);
	// ====
	// Released pin shows the inverse of the last driven level.
	logic last = 1'b0;
	always_ff @(posedge clk_i) begin
		if (!oe_n_i) begin
			last <= drive_i;
		end
	end
	assign level_o = oe_n_i ? ~last : drive_i;
endmodule
`default_nettype wire

// *** pwm_timer_pkg.sv ***
// Constants, register map and carrier types of the eight-bit PWM and interval timer.
// Assumes a 32-bit AHB-Lite register bus with one register per aligned word.

`default_nettype none

package pwm_timer_pkg;

	// ==========================================================
	// Sizes
	localparam int NUM_TIMERS = 2;
	localparam int CNT_W = 8;
	localparam int ADDR_W = 12;
	localparam int IDX_W = 10;
	localparam int SRC_W = 4;

	// ==========================================================
	// Bus encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HTRANS_SEQ = 2'h3;
	localparam logic HRESP_OKAY = 1'h0;

	// ==========================================================
	// Register indices; the byte address is four times the index.
	localparam logic [IDX_W-1:0] IDX_CTRL [NUM_TIMERS] = '{10'h01e, 10'h020};
	localparam logic [IDX_W-1:0] IDX_CMP [NUM_TIMERS] = '{10'h01f, 10'h021};
	localparam logic [IDX_W-1:0] IDX_COUNT [NUM_TIMERS] = '{10'h024, 10'h025};
	localparam logic [IDX_W-1:0] IDX_PORT = 10'h022;
	localparam logic [IDX_W-1:0] IDX_STANDBY = 10'h023;
	localparam logic [IDX_W-1:0] IDX_LEVEL = 10'h07e;

	// ==========================================================
	// Reset values, masks and field positions
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] CTRL_READ_MASK = 8'hbf;
	localparam logic [CNT_W-1:0] CMP_RESET = 8'h00;
	localparam logic [CNT_W-1:0] COUNT_ZERO = 8'h00;
	localparam logic [CNT_W-1:0] COUNT_TOP = 8'hff;
	localparam logic [7:0] LEVEL_RESET = 8'hff;
	localparam int LEVEL_LSB [NUM_TIMERS] = '{2, 4};
	localparam logic [7:0] PORT_RESET = 8'h00;
	localparam logic [7:0] PORT_WRITE_MASK = 8'h33;
	localparam int PORT_DATA_LSB = 0;
	localparam int PORT_DIR_LSB = 4;
	localparam int PORT_IN_LSB = 6;
	localparam logic [7:0] STANDBY_RESET = 8'h00;
	localparam int STANDBY_FLOAT_BIT = 0;

	// ==========================================================
	// Carrier types
	typedef struct packed {
		logic pwm_mode;
		logic unused;
		logic [1:0] clock_select;
		logic run_bit;
		logic match_flag;
		logic output_enable;
		logic match_irq_enable;
	} timer_control_t;

	typedef struct packed {
		logic valid;
		logic write;
		logic [IDX_W-1:0] index;
	} bus_phase_t;

	typedef struct packed {
		logic enable;
		logic level;
		logic port_level;
		logic port_out;
	} pin_request_t;

endpackage

`default_nettype wire

// *** shared_pin_driver.sv ***
// Driver for one shared pin: timer waveform or general-purpose port level.
// Assumes the pin level is resolved outside from the active-low enable.

`timescale 1ns/1ns
`default_nettype none

module shared_pin_driver
	import pwm_timer_pkg::*;
#(
	parameter bit PULL_UP = 1'b0
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Requested drive
	input wire pin_request_t request_i,
	input wire logic stop_i,
	input wire logic float_i,
	// Pin
	input wire logic pin_i,
	output logic pin_o,
	output logic pin_oe_n_o,
	// Synchronised pin level
	output logic level_o
);

	// ==========================================================
	// Drive selection
	logic sync_a;
	logic sync_b;
	wire logic drive_out = request_i.enable | request_i.port_out;
	wire logic level = request_i.enable ? request_i.level : request_i.port_level;
	wire logic next_oe_n = stop_i ? (float_i ? !PULL_UP : pin_oe_n_o) : !drive_out;
	wire logic next_pin = stop_i ? ((float_i & PULL_UP) | pin_o) : level;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pin_o <= 1'b0;
			pin_oe_n_o <= 1'b1;
			sync_a <= 1'b0;
			sync_b <= 1'b0;
		end else begin
			pin_o <= next_pin;
			pin_oe_n_o <= next_oe_n;
			sync_a <= pin_i;
			sync_b <= sync_a;
		end
	end

	assign level_o = sync_b;

endmodule

`default_nettype wire

// *** tb_eight_bit_pwm_interval_timer.sv ***
// Self-checking bench of the two-timer block over its register bus.
// Assumes free-running count source levels made on the same clock.
`timescale 1ns/1ns
`default_nettype none
module tb_eight_bit_pwm_interval_timer
	import pwm_timer_pkg::*;
;
	// ====
	// Signals
	logic CLOCK_I = 1'b0;
	logic RST_N_I = 1'b0;
	logic HSEL_I = 1'b0;
	logic HWRITE_I = 1'b0;
	logic STOP_MODE_I = 1'b0;
	logic HREADY_I;
	logic [ADDR_W-1:0] HADDR_I = '0;
	logic [1:0] HTRANS_I = 2'h0;
	logic [2:0] HSIZE_I = 3'h2;
	logic [31:0] HWDATA_I = 32'h0;
	logic [SRC_W-1:0] COUNT_SRC_ONE_I = 4'h0;
	logic [SRC_W-1:0] COUNT_SRC_TWO_I = 4'h0;
	logic [31:0] HRDATA_O;
	logic HREADYOUT_O, HRESP_O, FIRST_TIMER_IRQ_LINE_O, SECOND_TIMER_IRQ_LINE_O;
	logic [1:0] FIRST_IRQ_LEVEL_O, SECOND_IRQ_LEVEL_O;
	logic TIMER_ONE_OUTPUT_PIN_I, TIMER_ONE_OUTPUT_PIN_O, TIMER_ONE_OUTPUT_PIN_OE_N_O;
	logic TIMER_TWO_OUTPUT_PIN_I, TIMER_TWO_OUTPUT_PIN_O, TIMER_TWO_OUTPUT_PIN_OE_N_O;
	int mismatches = 0;
	int checks_done = 0;
	int cyc = 0;
	int n;
	logic [31:0] q;
	logic [31:0] m;
	logic [7:0] iv [3] = '{8'h03, 8'h00, 8'h01};
	logic [7:0] cv [3] = '{8'h0a, 8'h0a, 8'h1a};
	int tp [3] = '{2, 2, 4};
	logic [7:0] dv [3] = '{8'h00, 8'h80, 8'hff};
	assign HREADY_I = HREADYOUT_O;
	eight_bit_pwm_interval_timer i_dut (.*);
	pin_load i_load_one (.clk_i(CLOCK_I), .drive_i(TIMER_ONE_OUTPUT_PIN_O),
		.oe_n_i(TIMER_ONE_OUTPUT_PIN_OE_N_O), .level_o(TIMER_ONE_OUTPUT_PIN_I));
	pin_load i_load_two (.clk_i(CLOCK_I), .drive_i(TIMER_TWO_OUTPUT_PIN_O),
		.oe_n_i(TIMER_TWO_OUTPUT_PIN_OE_N_O), .level_o(TIMER_TWO_OUTPUT_PIN_I));
	always #5 CLOCK_I = ~CLOCK_I;
	always @(posedge CLOCK_I) begin
		COUNT_SRC_ONE_I <= COUNT_SRC_ONE_I + 4'h1;
		COUNT_SRC_TWO_I <= COUNT_SRC_TWO_I + 4'h1;
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			results;
		end
	end
	// ====
	// Tasks
	task results;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task wt(input int k);
		repeat (k) @(posedge CLOCK_I);
		#1;
	endtask
	task bus(input logic w, input logic [IDX_W-1:0] i, input logic [7:0] d);
		@(posedge CLOCK_I);
		HSEL_I <= 1'b1;
		HTRANS_I <= HTRANS_NONSEQ;
		HADDR_I <= {i, 2'b00};
		HWRITE_I <= w;
		do @(posedge CLOCK_I); while (HREADY_I !== 1'b1);
		HSEL_I <= 1'b0;
		HTRANS_I <= 2'h0;
		HWDATA_I <= {24'h0, d};
		do @(posedge CLOCK_I); while (HREADY_I !== 1'b1);
		q = HRDATA_O;
		chk("response", HRESP_O, 32'h0);
		#1;
	endtask
	task rdc(input string nm, input logic [IDX_W-1:0] i, input logic [31:0] e);
		bus(1'b0, i, 8'h00);
		chk(nm, q, e);
	endtask
	task gap(output int g);
		logic p;
		g = 0;
		for (int k = 0; k < 2; k++) begin
			p = TIMER_ONE_OUTPUT_PIN_O;
			g = 0;
			while (TIMER_ONE_OUTPUT_PIN_O === p && g < 600) begin
				wt(1);
				g++;
			end
		end
	endtask
	// ====
	// Tests
	initial begin
		repeat (20) @(posedge CLOCK_I);
		RST_N_I <= 1'b1;
		rdc("level reset", IDX_LEVEL, 32'hff);
		rdc("unmapped", 10'h3ff, 32'h0);
		bus(1'b1, IDX_LEVEL, 8'h24);
		chk("level one", FIRST_IRQ_LEVEL_O, 32'h1);
		chk("level two", SECOND_IRQ_LEVEL_O, 32'h2);
		$display("test levels done");
		for (int k = 0; k < 3; k++) begin
			bus(1'b1, IDX_CMP[0], iv[k]);
			bus(1'b1, IDX_CTRL[0], cv[k]);
			gap(n);
			chk("toggle gap", n, tp[k] * (iv[k] + 1));
			bus(1'b1, IDX_CTRL[0], 8'h02);
			wt(3);
			chk("stopped pin", TIMER_ONE_OUTPUT_PIN_O, 32'h0);
		end
		$display("test interval done");
		bus(1'b1, IDX_CMP[0], 8'h03);
		bus(1'b1, IDX_CTRL[0], 8'h0a);
		wt(20);
		chk("masked irq", FIRST_TIMER_IRQ_LINE_O, 32'h0);
		bus(1'b1, IDX_CTRL[0], 8'h07);
		chk("late enable", FIRST_TIMER_IRQ_LINE_O, 32'h1);
		rdc("flag kept", IDX_CTRL[0], 32'h07);
		rdc("count zero", IDX_COUNT[0], 32'h0);
		bus(1'b1, IDX_CTRL[0], 8'h03);
		chk("flag clear", FIRST_TIMER_IRQ_LINE_O, 32'h0);
		$display("test flag done");
		bus(1'b1, IDX_CTRL[0], 8'h00);
		bus(1'b1, IDX_CTRL[0], 8'h8b);
		for (int k = 0; k < 3; k++) begin
			bus(1'b1, IDX_CMP[0], dv[k]);
			wt(600);
			n = 0;
			repeat (512) begin
				wt(1);
				n += TIMER_ONE_OUTPUT_PIN_O;
			end
			chk("high time", n, 2 * dv[k]);
			chk("pulse irq", FIRST_TIMER_IRQ_LINE_O, 32'h0);
		end
		bus(1'b1, IDX_CTRL[0], 8'h83);
		wt(10);
		bus(1'b1, IDX_CTRL[0], 8'h00);
		$display("test pulse done");
		bus(1'b1, IDX_CMP[1], 8'h00);
		bus(1'b1, IDX_CTRL[1], 8'h09);
		wt(8);
		chk("second irq", SECOND_TIMER_IRQ_LINE_O, 32'h1);
		chk("first quiet", FIRST_TIMER_IRQ_LINE_O, 32'h0);
		bus(1'b1, IDX_CTRL[1], 8'h00);
		$display("test second done");
		bus(1'b1, IDX_STANDBY, 8'h01);
		bus(1'b1, IDX_CMP[0], 8'h40);
		bus(1'b1, IDX_CTRL[0], 8'h0a);
		wt(20);
		@(posedge CLOCK_I);
		STOP_MODE_I <= 1'b1;
		wt(4);
		chk("stop float", TIMER_ONE_OUTPUT_PIN_OE_N_O, 32'h1);
		bus(1'b0, IDX_COUNT[0], 8'h00);
		m = q;
		wt(10);
		rdc("frozen", IDX_COUNT[0], m);
		@(posedge CLOCK_I);
		STOP_MODE_I <= 1'b0;
		wt(6);
		bus(1'b0, IDX_COUNT[0], 8'h00);
		chk("resumed", q > m, 32'h1);
		bus(1'b1, IDX_CTRL[0], 8'h00);
		$display("test stop done");
		bus(1'b1, IDX_PORT, 8'h33);
		wt(3);
		chk("port drive", TIMER_ONE_OUTPUT_PIN_OE_N_O, 32'h0);
		chk("port level", TIMER_ONE_OUTPUT_PIN_O, 32'h1);
		chk("port two drive", TIMER_TWO_OUTPUT_PIN_OE_N_O, 32'h0);
		chk("port two level", TIMER_TWO_OUTPUT_PIN_O, 32'h1);
		rdc("port read", IDX_PORT, 32'hf3);
		$display("test port done");
		results;
	end
endmodule
`default_nettype wire
